// ==== rtl/fdc_defs.svh ====
// Constants shared by both ends of the diskette controller host port
`ifndef FDC_DEFS_SVH
`define FDC_DEFS_SVH
`define FDC_ADDR_STATUS 1'b0
`define FDC_ADDR_DATA 1'b1
`define FDC_MSR_RQM 7
`define FDC_MSR_DIO 6
`define FDC_MSR_NDMA 5
`define FDC_MSR_CB 4
`define FDC_FIFO_DEPTH 16
`define FDC_PARAM_BYTES 9
`define FDC_OP_READ 5'h06
`define FDC_OP_WRITE 5'h05
`define FDC_OP_SPECIFY 5'h03
`define FDC_OP_CONFIGURE 5'h13
`define FDC_OP_SENSE 5'h08
`define FDC_LEN_XFER 4'h9
`define FDC_LEN_SPECIFY 4'h3
`define FDC_LEN_CONFIGURE 4'h4
`define FDC_LEN_SENSE 4'h1
`define FDC_RES_XFER 3'h7
`define FDC_RES_SENSE 3'h2
`define FDC_SPEC_NDMA_BIT 0
`define FDC_CFG_FIFO_OFF_BIT 5
`define FDC_EOT_INDEX 6
`define FDC_ST0_ABNORMAL 8'h40
`define FDC_ST0_INVALID 8'h80
`endif

// ==== rtl/fdc_device_end.sv ====
// Controller end: phase sequencing, status handshake and data FIFO
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - Reset enters command phase, ready for byte
// - Host writes only when ready and outbound
// - Ready drops after each byte, returns per parameter
// - Last parameter: stay busy, advance phase (specify and configure drop busy, stay in command)
// - FIFO unused during command phase
// - Data moves only in execution phase
// - Reset leaves FIFO off; configure enables it
// - Threshold is programmed value plus one
// - Polled read requests at fill level
// - Polled write requests from entry until full
// - Polled write drops interrupt on plain write
// - Write ends after disk empties FIFO
// - DMA read requests at fill level
// - DMA request drops on final byte
// - DMA write requests until full, rearms
// - Terminal count with ack drops request
// - DMA writes use ack with write strobe
// - End on count, error or last sector
// - Implicit end reports abnormal status
// - Host tolerates late request removal
// - Interrupt starts result phase except after sense; read all
// - Host reads results only when both set
// - After results: ready, outbound, not busy
// - Bad opcode interrupts; sense reports error
module fdc_device_end #(
  parameter int DEPTH = `FDC_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  fdc_link_if.device link,
  input wire logic disk_in_valid,
  input wire logic [7:0] disk_in_data,
  output logic disk_in_ready,
  output logic disk_out_valid,
  output logic [7:0] disk_out_data,
  input wire logic disk_out_ready,
  input wire logic sector_last,
  input wire logic disk_done,
  input wire logic disk_error,
  output logic exec_read,
  output logic exec_write,
  output logic [7:0] eot_param
);
  fdc_pkg::dev_state_type q, d;

  function automatic logic [3:0] cmd_len(input logic [4:0] op);
    case (op)
      `FDC_OP_READ: cmd_len = `FDC_LEN_XFER;
      `FDC_OP_WRITE: cmd_len = `FDC_LEN_XFER;
      `FDC_OP_SPECIFY: cmd_len = `FDC_LEN_SPECIFY;
      `FDC_OP_CONFIGURE: cmd_len = `FDC_LEN_CONFIGURE;
      `FDC_OP_SENSE: cmd_len = `FDC_LEN_SENSE;
      default: cmd_len = 4'h0;
    endcase
  endfunction

  function automatic logic [7:0] result_byte(input fdc_pkg::dev_state_type s);
    if (s.ridx == 3'h0)
      result_byte = s.st0;
    else if (s.ridx >= 3'h3)
      result_byte = s.params[4'(s.ridx) - 4'h1];
    else
      result_byte = 8'h00;
  endfunction

  logic exec;
  logic host_wr;
  logic host_rd;
  logic xfer_wr;
  logic xfer_rd;
  logic push;
  logic pop;
  logic tc_evt;
  logic done;
  logic [4:0] cap;
  logic [4:0] level;
  logic [4:0] rearm;
  logic [3:0] len;
  logic [7:0] msr;

  ////////////////////////////////////////////////////////////////////////
  // Access decode and FIFO sizing
  always_comb begin
    exec = q.phase == fdc_pkg::PH_EXEC;
    host_wr = link.wr && link.addr == `FDC_ADDR_DATA;
    host_rd = link.rd && link.addr == `FDC_ADDR_DATA;
    xfer_wr = exec && !q.dir_rd && (q.ndma ? host_wr : (!link.dma_ack_n && link.wr));
    xfer_rd = exec && q.dir_rd && (q.ndma ? host_rd : (!link.dma_ack_n && link.rd));
    // FIFO off means one byte per request
    cap = q.fifo_en ? 5'(DEPTH) : 5'h01;
    level = q.fifo_en ? 5'(DEPTH) - ({1'b0, q.thr} + 5'h01) : 5'h01;
    rearm = q.fifo_en ? {1'b0, q.thr} + 5'h01 : 5'h00;
    push = q.dir_rd ? (disk_in_valid && disk_in_ready) : (xfer_wr && q.cnt < cap);
    pop = q.dir_rd ? (xfer_rd && q.cnt != 5'h00) : (disk_out_valid && disk_out_ready);
    // count qualified by ack or strobe
    tc_evt = exec && link.tc && (q.ndma ? (xfer_wr || xfer_rd) : !link.dma_ack_n);
    len = cmd_len(q.params[0][4:0]);
    msr = {q.request_for_master, q.phase == fdc_pkg::PH_RESULT || (exec && q.dir_rd && q.ndma), exec && q.ndma, q.cb, 4'h0};
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    done = 1'b0;
    if (link.rd) begin
      if (link.addr == `FDC_ADDR_STATUS && link.dma_ack_n)
        d.rdata = msr;
      else if (q.phase == fdc_pkg::PH_RESULT)
        d.rdata = result_byte(q);
      else if (xfer_rd)
        d.rdata = q.mem[q.rp];
      else
        d.rdata = 8'h00;
    end
    case (q.phase)
      fdc_pkg::PH_CMD: begin
        if (host_wr && q.request_for_master) begin
          d.params[q.idx] = link.wdata;
          d.idx = q.idx + 4'h1;
          d.request_for_master = 1'b0;
          d.cb = 1'b1;
          d.irq = 1'b0;
          d.phase = fdc_pkg::PH_PROC;
        end
      end
      fdc_pkg::PH_PROC: begin
        d.phase = fdc_pkg::PH_CMD;
        if (len == 4'h0) begin
          d.invalid = 1'b1;
          d.irq = 1'b1;
          d.idx = 4'h0;
          d.request_for_master = 1'b1;
          d.cb = 1'b0;
        end else if (q.idx < len) begin
          d.request_for_master = 1'b1;
        end else begin
          d.idx = 4'h0;
          d.request_for_master = 1'b1;
          d.cb = 1'b0;
          case (q.params[0][4:0])
            `FDC_OP_SPECIFY: d.ndma = q.params[2][`FDC_SPEC_NDMA_BIT];
            `FDC_OP_CONFIGURE: begin
              d.fifo_en = ~q.params[2][`FDC_CFG_FIFO_OFF_BIT];
              d.thr = q.params[2][3:0];
            end
            `FDC_OP_SENSE: begin
              d.st0 = q.invalid ? `FDC_ST0_INVALID : q.st0;
              d.invalid = 1'b0;
              d.rlen = `FDC_RES_SENSE;
              d.ridx = 3'h0;
              d.cb = 1'b1;
              d.phase = fdc_pkg::PH_RESULT;
            end
            default: begin
              d.dir_rd = q.params[0][4:0] == `FDC_OP_READ;
              d.wp = 4'h0;
              d.rp = 4'h0;
              d.cnt = 5'h00;
              d.tc_seen = 1'b0;
              d.end_seen = 1'b0;
              d.err_seen = 1'b0;
              d.req = q.params[0][4:0] == `FDC_OP_WRITE;
              d.irq = q.ndma && q.params[0][4:0] == `FDC_OP_WRITE;
              d.request_for_master = q.ndma && q.params[0][4:0] == `FDC_OP_WRITE;
              d.cb = 1'b1;
              d.phase = fdc_pkg::PH_EXEC;
            end
          endcase
        end
      end
      fdc_pkg::PH_EXEC: begin
        if (push) begin
          d.mem[q.wp] = q.dir_rd ? disk_in_data : link.wdata;
          d.wp = q.wp + 4'h1;
        end
        if (pop)
          d.rp = q.rp + 4'h1;
        d.cnt = q.cnt + 5'(push) - 5'(pop);
        if (tc_evt)
          d.tc_seen = 1'b1;
        if (disk_done)
          d.end_seen = 1'b1;
        if (disk_error || (xfer_wr && q.cnt >= cap) || (xfer_rd && q.cnt == 5'h00))
          d.err_seen = 1'b1;
        if (q.dir_rd) begin
          if (d.cnt == 5'h00 || d.tc_seen)
            d.req = 1'b0;
          else if (d.cnt >= level || sector_last)
            d.req = 1'b1;
        end else begin
          // hold until full, rearm at threshold
          if (d.cnt >= cap || d.tc_seen || d.end_seen)
            d.req = 1'b0;
          else if (d.cnt <= rearm)
            d.req = 1'b1;
        end
        if (q.ndma) begin
          if (!d.req)
            d.irq = 1'b0;
          else if (!q.req)
            d.irq = 1'b1;
          if (!q.dir_rd && xfer_wr && !link.tc && link.dma_ack_n)
            d.irq = 1'b0;
        end
        d.request_for_master = q.ndma && d.req;
        // finish only once FIFO is empty
        done = (d.tc_seen || d.end_seen || d.err_seen) && d.cnt == 5'h00;
        if (done) begin
          d.st0 = d.tc_seen && !d.err_seen ? 8'h00 : `FDC_ST0_ABNORMAL;
          d.req = 1'b0;
          d.irq = 1'b1;
          d.request_for_master = 1'b1;
          d.ridx = 3'h0;
          d.rlen = `FDC_RES_XFER;
          d.phase = fdc_pkg::PH_RESULT;
        end
      end
      fdc_pkg::PH_RESULT: begin
        if (host_rd && q.request_for_master) begin
          d.irq = 1'b0;
          d.ridx = q.ridx + 3'h1;
          // all read: ready for next command
          if (q.ridx == q.rlen - 3'h1) begin
            d.request_for_master = 1'b1;
            d.cb = 1'b0;
            d.idx = 4'h0;
            d.phase = fdc_pkg::PH_CMD;
          end
        end
      end
      default: d.phase = fdc_pkg::PH_CMD;
    endcase
    if (rst) begin
      d = '0;
      d.request_for_master = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // disk side sees FIFO only while executing
  assign exec_read = exec && q.dir_rd;
  assign exec_write = exec && !q.dir_rd;
  assign disk_in_ready = exec_read && q.cnt < cap && !q.tc_seen;
  assign disk_out_valid = exec_write && q.cnt != 5'h00;
  assign disk_out_data = q.mem[q.rp];
  assign eot_param = q.params[`FDC_EOT_INDEX];
  assign link.rdata = q.rdata;
  assign link.host_irq = q.irq;
  // request ends with final acked byte
  assign link.dma_req = exec && !q.ndma && q.req;
endmodule

// ==== rtl/fdc_host_end.sv ====
// Processor and DMA end: polls status, sends command bytes, moves data
`timescale 1ns/1ps
module fdc_host_end (
  input wire logic clk,
  input wire logic rst,
  fdc_link_if.host link,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  input wire logic dma_to_host,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_result
);
  fdc_pkg::host_state_type q, d;

  always_comb begin
    d = q;
    d.rd = 1'b0;
    d.wr = 1'b0;
    d.tc = 1'b0;
    d.ack_n = 1'b1;
    d.rx_valid = 1'b0;
    tx_ready = 1'b0;
    case (q.st)
      fdc_pkg::HS_POLL: begin
        if (link.dma_req && dma_to_host) begin
          d.ack_n = 1'b0;
          d.rd = 1'b1;
          d.rx_result = 1'b0;
          d.st = fdc_pkg::HS_WAIT_D;
        end else if (link.dma_req && tx_valid) begin
          d.ack_n = 1'b0;
          d.wr = 1'b1;
          d.wdata = tx_data;
          d.tc = tx_last;
          tx_ready = 1'b1;
          d.st = fdc_pkg::HS_GAP;
        end else begin
          d.rd = 1'b1;
          d.addr = `FDC_ADDR_STATUS;
          d.st = fdc_pkg::HS_WAIT_S;
        end
      end
      fdc_pkg::HS_WAIT_S: d.st = fdc_pkg::HS_STAT;
      fdc_pkg::HS_STAT: begin
        d.st = fdc_pkg::HS_POLL;
        if (link.rdata[`FDC_MSR_RQM] && link.rdata[`FDC_MSR_DIO]) begin
          d.rd = 1'b1;
          d.addr = `FDC_ADDR_DATA;
          d.rx_result = ~link.rdata[`FDC_MSR_NDMA];
          d.st = fdc_pkg::HS_WAIT_D;
        end else if (link.rdata[`FDC_MSR_RQM] && !link.rdata[`FDC_MSR_DIO] && tx_valid) begin
          d.wr = 1'b1;
          d.addr = `FDC_ADDR_DATA;
          d.wdata = tx_data;
          d.tc = tx_last & link.rdata[`FDC_MSR_NDMA];
          tx_ready = 1'b1;
        end
      end
      fdc_pkg::HS_WAIT_D: d.st = fdc_pkg::HS_GET;
      fdc_pkg::HS_GET: begin
        d.rx_valid = 1'b1;
        d.rx_data = link.rdata;
        d.st = fdc_pkg::HS_POLL;
      end
      fdc_pkg::HS_GAP: d.st = fdc_pkg::HS_POLL;
      default: d.st = fdc_pkg::HS_POLL;
    endcase
    if (rst) begin
      d = '0;
      d.ack_n = 1'b1;
      tx_ready = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign link.rd = q.rd;
  assign link.wr = q.wr;
  assign link.addr = q.addr;
  assign link.wdata = q.wdata;
  assign link.tc = q.tc;
  assign link.dma_ack_n = q.ack_n;
  assign rx_valid = q.rx_valid;
  assign rx_data = q.rx_data;
  assign rx_result = q.rx_result;
endmodule

// ==== rtl/fdc_link_if.sv ====
// Host port link between processor/DMA end and controller end
`timescale 1ns/1ps
interface fdc_link_if (
  input wire logic clk
);
  logic rd;
  logic wr;
  logic addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic host_irq;
  logic dma_req;
  logic dma_ack_n;
  logic tc;

  modport device (input clk, input rd, input wr, input addr, input wdata, input dma_ack_n, input tc,
                  output rdata, output host_irq, output dma_req);
  modport host (input clk, output rd, output wr, output addr, output wdata, output dma_ack_n, output tc,
                input rdata, input host_irq, input dma_req);
endinterface

// ==== rtl/fdc_pkg.sv ====
// Types shared by both ends of the diskette controller host port
`include "fdc_defs.svh"
package fdc_pkg;
  typedef enum logic [1:0] {PH_CMD, PH_PROC, PH_EXEC, PH_RESULT} phase_type;

  typedef struct packed {
    phase_type phase;
    logic request_for_master;
    logic cb;
    logic irq;
    logic req;
    logic [3:0] idx;
    logic [2:0] ridx;
    logic [2:0] rlen;
    logic [`FDC_PARAM_BYTES-1:0][7:0] params;
    logic [`FDC_FIFO_DEPTH-1:0][7:0] mem;
    logic [3:0] wp;
    logic [3:0] rp;
    logic [4:0] cnt;
    logic fifo_en;
    logic [3:0] thr;
    logic ndma;
    logic dir_rd;
    logic tc_seen;
    logic end_seen;
    logic err_seen;
    logic invalid;
    logic [7:0] st0;
    logic [7:0] rdata;
  } dev_state_type;

  typedef enum logic [2:0] {HS_POLL, HS_WAIT_S, HS_STAT, HS_WAIT_D, HS_GET, HS_GAP} host_phase_type;

  typedef struct packed {
    host_phase_type st;
    logic rd;
    logic wr;
    logic addr;
    logic [7:0] wdata;
    logic tc;
    logic ack_n;
    logic rx_pend;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_result;
  } host_state_type;
endpackage

// ==== test/diskette_ctrl_phase_fifo_handshake_tb.sv ====
// Testbench joining both ends of the diskette host port
`timescale 1ns/1ps
module diskette_ctrl_phase_fifo_handshake_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_last = 1'b0;
  logic dma_to_host = 1'b0;
  logic disk_in_valid = 1'b0;
  logic [7:0] disk_in_data = 8'h00;
  logic disk_out_ready = 1'b0;
  logic sector_last = 1'b0;
  logic disk_done = 1'b0;
  logic disk_error = 1'b0;
  logic tx_ready, rx_valid, rx_result, disk_in_ready, disk_out_valid, exec_read, exec_write;
  logic [7:0] rx_data, disk_out_data, eot_param;
  logic [8:0] rxq[$];
  logic [7:0] dq[$];
  logic [7:0] cmd[$];
  int fail_count = 0;
  int checks = 0;
  always #5 clk = ~clk;
  fdc_link_if link (.clk(clk));
  fdc_host_end fdc_host_end_i (.clk(clk), .rst(rst), .link(link), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .dma_to_host(dma_to_host), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_result(rx_result));
  fdc_device_end fdc_device_end_i (.clk(clk), .rst(rst), .link(link), .disk_in_valid(disk_in_valid),
    .disk_in_data(disk_in_data), .disk_in_ready(disk_in_ready), .disk_out_valid(disk_out_valid),
    .disk_out_data(disk_out_data), .disk_out_ready(disk_out_ready), .sector_last(sector_last),
    .disk_done(disk_done), .disk_error(disk_error), .exec_read(exec_read), .exec_write(exec_write),
    .eot_param(eot_param));
  fdc_link_properties fdc_link_properties_i (.clk(clk), .rst(rst), .rd(link.rd), .wr(link.wr),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .host_irq(link.host_irq),
    .dma_req(link.dma_req), .dma_ack_n(link.dma_ack_n), .tc(link.tc));
  ////////////////////////////////////////////////////////////////
  // Collect host bytes; disk side stalls every other cycle
  always @(posedge clk) begin
    if (rx_valid === 1'b1) rxq.push_back({rx_result, rx_data});
    if (disk_out_valid === 1'b1 && disk_out_ready === 1'b1) dq.push_back(disk_out_data);
    disk_out_ready <= ~disk_out_ready;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang(input string what);
    fail_count++;
    $display("MISMATCH %s expected done seen timeout", what);
    wrap_up();
  endtask
  task automatic wait_hi(ref logic s, input string what);
    int k;
    k = 0;
    while (s !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) hang(what);
  endtask
  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (rxq.size() < n && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) hang("rx count");
  endtask
  // Hand the queued bytes to the host end, tc on the final one if asked
  task automatic send(input bit last);
    int k;
    foreach (cmd[i]) begin
      tx_valid <= 1'b1;
      tx_data <= cmd[i];
      tx_last <= last && i == cmd.size() - 1;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (tx_ready !== 1'b1 && k < 3000);
      if (k >= 3000) hang("tx_ready");
    end
    tx_valid <= 1'b0;
    tx_last <= 1'b0;
    cmd.delete();
  endtask
  task automatic feed(input int a, input int z);
    int k;
    for (int i = a; i < z; i++) begin
      disk_in_valid <= 1'b1;
      disk_in_data <= 8'h40 + i[7:0];
      sector_last <= i == 19;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (disk_in_ready !== 1'b1 && k < 3000);
      if (k >= 3000) hang("disk_in_ready");
    end
    disk_in_valid <= 1'b0;
  endtask
  task automatic load(input logic [7:0] op);
    cmd = '{op, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h1b, 8'hff};
  endtask
  task automatic results(input logic [7:0] st0, input int b);
    logic [7:0] e[7];
    e = '{st0, 8'h00, 8'h00, 8'h02, 8'h03, 8'h04, 8'h05};
    wait_rx(b + 7);
    foreach (e[i]) chk("result byte", {1'b1, e[i]}, rxq[b + i]);
  endtask
  // Threshold 4: nothing moves until 12 bytes wait
  task automatic read_run(input bit use_err);
    load(8'h06);
    rxq.delete();
    send(1'b0);
    wait_hi(exec_read, "exec_read");
    chk("end sector", 9'h007, {1'b0, eot_param});
    feed(0, 11);
    repeat (40) @(posedge clk);
    chk("early data", 9'h000, 9'(rxq.size()));
    feed(11, 20);
    wait_rx(20);
    repeat (2) @(posedge clk);
    chk("request when empty", 9'h000, {7'h00, link.host_irq, link.dma_req});
    foreach (rxq[i]) chk("read data", {1'b0, 8'h40 + i[7:0]}, rxq[i]);
    if (use_err) disk_error <= 1'b1;
    else disk_done <= 1'b1;
    sector_last <= 1'b0;
    @(posedge clk);
    disk_error <= 1'b0;
    disk_done <= 1'b0;
    results(8'h40, 20);
  endtask
  // Eight bytes ending on tc; polled mode announces entry by interrupt
  task automatic write_run(input bit polled);
    load(8'h05);
    rxq.delete();
    dq.delete();
    send(1'b0);
    wait_hi(exec_write, "exec_write");
    if (polled) wait_hi(link.host_irq, "write irq");
    else chk("write request", 9'h001, {7'h00, link.host_irq, link.dma_req});
    for (int i = 0; i < 8; i++) cmd.push_back(8'hd0 + i[7:0]);
    send(1'b1);
    wait_rx(1);
    chk("bytes on disk", 9'h008, 9'(dq.size()));
    foreach (dq[i]) chk("disk data", {1'b0, 8'hd0 + i[7:0]}, {1'b0, dq[i]});
    results(8'h00, 0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk("idle request", 9'h000, {7'h00, link.host_irq, link.dma_req});
    chk("fifo in command", 9'h000, {7'h00, disk_in_ready, disk_out_valid});
    cmd = '{8'h13, 8'h00, 8'h03, 8'h00};
    send(1'b0);
    dma_to_host <= 1'b1;
    read_run(1'b0);
    dma_to_host <= 1'b0;
    write_run(1'b0);
    cmd = '{8'h03, 8'h00, 8'h01};
    send(1'b0);
    read_run(1'b1);
    write_run(1'b1);
    rxq.delete();
    cmd = '{8'h1f};
    send(1'b0);
    wait_hi(link.host_irq, "invalid irq");
    cmd = '{8'h08};
    send(1'b0);
    wait_rx(2);
    chk("sense status", 9'h180, rxq[0]);
    wrap_up();
  end
endmodule

// ==== test/fdc_link_properties.sv ====
// Link checks for the diskette host port
`timescale 1ns/1ps
`include "fdc_defs.svh"
module fdc_link_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic rd,
  input wire logic wr,
  input wire logic addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic host_irq,
  input wire logic dma_req,
  input wire logic dma_ack_n,
  input wire logic tc
);
  logic stat_q;
  logic [7:0] msr_q;
  logic data_wr;
  logic data_rd;
  logic bad_op;
  assign data_wr = wr && addr && dma_ack_n;
  assign data_rd = rd && addr && dma_ack_n;
  assign bad_op = !(wdata[4:0] inside {`FDC_OP_READ, `FDC_OP_WRITE, `FDC_OP_SPECIFY, `FDC_OP_CONFIGURE,
    `FDC_OP_SENSE});
  // Last status byte the host has seen
  always_ff @(posedge clk) begin
    stat_q <= !rst && rd && !addr && dma_ack_n;
    if (rst) begin
      msr_q <= 8'h00;
    end else if (stat_q) begin
      msr_q <= rdata;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  chk_reset_quiet: assert property ($fell(rst) |-> !host_irq && !dma_req)
    else $error("request after reset");
  chk_byte_drops_ready: assert property (data_wr ##1 (rd && !addr && dma_ack_n)
    |=> !rdata[`FDC_MSR_RQM] || rdata[`FDC_MSR_NDMA]) else $error("ready not cleared after byte");
  chk_write_when_ready: assert property (data_wr |-> msr_q[`FDC_MSR_RQM] && !msr_q[`FDC_MSR_DIO])
    else $error("byte written while not ready");
  chk_read_when_ready: assert property (data_rd |-> msr_q[`FDC_MSR_RQM] && msr_q[`FDC_MSR_DIO])
    else $error("byte read while not ready");
  chk_ack_one_strobe: assert property (!dma_ack_n |-> rd != wr)
    else $error("ack without single strobe");
  chk_count_drops_req: assert property (!dma_ack_n && tc |=> !dma_req)
    else $error("request kept after count");
  chk_idle_outbound: assert property (stat_q && !rdata[`FDC_MSR_CB]
    |-> rdata[`FDC_MSR_RQM] && !rdata[`FDC_MSR_DIO]) else $error("idle status wrong");
  chk_rdata_held: assert property (!$past(rd) |-> $stable(rdata))
    else $error("read data moved without read");
  chk_bad_op_irq: assert property (data_wr && !msr_q[`FDC_MSR_CB] && bad_op |-> ##[1:4] host_irq)
    else $error("no interrupt for bad opcode");
  chk_plain_write_irq: assert property (data_wr && !tc && msr_q[`FDC_MSR_NDMA] |=> !host_irq)
    else $error("interrupt kept after plain write");
  ////////////////////////////////////////////////////////////////
  cov_dma_write: cover property (!dma_ack_n && wr);
  cov_dma_read: cover property (!dma_ack_n && rd);
  cov_irq: cover property ($rose(host_irq));
  cov_polled_write: cover property (data_wr && msr_q[`FDC_MSR_NDMA]);
endmodule
